// ### pwm_out_pkg.sv
/*
 * Shared constants for the PWM output stage: register map, field
 * positions, reset values and timing counts.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none
package pwm_out_pkg;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 16;
	localparam logic [ADDR_W-1:0] TB_CTRL_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] PIN_CTRL_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] PERIOD_OFF = 8'h08;
	localparam logic [ADDR_W-1:0] DUTY_OFF = 8'h0C;
	localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h10;
	localparam int TB_ON_BIT = 15;
	localparam int EXT_RST_EN_BIT = 0;
	localparam int HI_OWN_BIT = 15;
	localparam int LO_OWN_BIT = 14;
	localparam int HI_OVR_BIT = 9;
	localparam int LO_OVR_BIT = 8;
	localparam int OVR_HI_LVL_BIT = 1;
	localparam int OVR_LO_LVL_BIT = 0;
	localparam logic [31:0] TB_CTRL_MASK = 32'h0000_8001;
	localparam logic [31:0] PIN_CTRL_MASK = 32'h0000_C303;
	localparam logic [31:0] CNT_MASK = 32'h0000_FFFF;
	localparam logic [31:0] TB_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] PIN_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] PERIOD_RST = 32'h0000_03E7;
	localparam logic [31:0] DUTY_RST = 32'h0000_01F4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SYNC_PULSE_NS = 100;
	localparam int SYNC_CYC_I = (SYNC_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
		SYNC_PULSE_NS / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] SYNC_CYC = CNT_W'(SYNC_CYC_I);
endpackage : pwm_out_pkg
`default_nettype wire

// ### tb_link_if.sv
/*
 * Carrier between the output controller and its time base counter.
 * Assumes both ends sit on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
interface tb_link_if;
	import pwm_out_pkg::*;
	logic en;
	logic ext_rst;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] duty;
	logic [CNT_W-1:0] count;
	logic on;
	logic start;
	modport ctrl (output en, ext_rst, period, duty, input count, on, start);
	modport tb (input en, ext_rst, period, duty, output count, on, start);
endinterface : tb_link_if
`default_nettype wire

// ### pwm_timebase.sv
/*
 * PWM time base: free counter from 0 to period, ON while count < duty.
 * Assumes period and duty are stable register values from the controller.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_timebase
	import pwm_out_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	tb_link_if.tb link
);
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic start_reg;
	logic start_next;

	always_comb
	begin
		count_next = count_reg;
		start_next = 1'b0;
		if (!link.en)
			count_next = '0;
		else if (link.ext_rst || count_reg >= link.period)
		begin
			count_next = '0;
			start_next = 1'b1;
		end
		else
			count_next = count_reg + CNT_W'(1);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_reg <= '0;
			start_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			start_reg <= start_next;
		end
	end

	assign link.count = count_reg;
	assign link.on = link.en && (count_reg < link.duty);
	assign link.start = start_reg;
endmodule : pwm_timebase
`default_nettype wire

// ### pwm_output_ctrl.sv
/*
 * PWM output control: pin ownership, override, time base enable,
 * external period reset qualification and secondary sync output,
 * with an AXI4-Lite register slave.
 * Assumes all inputs synchronous to clk_sys; pads resolve the enables.
 */
// Overview of operation
// (R1) ext period reset seen during OFF time restarts the period.
// (R2) ext reset held from ON time into OFF time is ignored.
// (R3) the reset source should assert only in OFF, release before ON ends.
// (R4) owner bit 1 gives the pin to PWM, 0 to the general port.
// (R5) two-bit override level sets high and low levels under override.
// (R6) override enable forces its output to the override level bit.
// (R7) timebase_on set starts the time base and output generation.
// (R8) software first parks pins as pulled inputs owned by the port.
// (R9) then level, overrides on, enable, overrides off, wait, give to PWM.
// (R10) sync_out_secondary pulses at each period start for a slave; the code gives no pulse for the first period after timebase_on.
// (R11) on faulty parts a spare output with ~100 ns pulse serves as sync.
// (R12) ownership and override changes act next edge, glitch-free.
`timescale 1ns/1ps
`default_nettype none
module pwm_output_ctrl
	import pwm_out_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_reset_in,
	input wire logic [1:0] port_data,
	input wire logic [1:0] port_direction,
	output logic out_high,
	output logic out_high_oe,
	output logic out_low,
	output logic out_low_oe,
	output logic sync_out_secondary
);
	tb_link_if link ();

	logic [31:0] tb_ctrl_reg, tb_ctrl_next;
	logic [31:0] pin_ctrl_reg, pin_ctrl_next;
	logic [31:0] period_reg, period_next;
	logic [31:0] duty_reg, duty_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic held_reg, held_next;
	logic [1:0] out_reg, out_next;
	logic [1:0] oe_reg, oe_next;
	logic sync_reg, sync_next;
	logic wr_go;
	logic rd_go;
	logic ext_rst_req;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb,
		input logic [31:0] mask);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r & mask;
	endfunction : merge

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return a == TB_CTRL_OFF || a == PIN_CTRL_OFF || a == PERIOD_OFF ||
			a == DUTY_OFF || a == STATUS_OFF;
	endfunction : mapped

	// address and data are taken together; one write and one read in flight
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign rd_go = s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	always_comb
	begin
		tb_ctrl_next = tb_ctrl_reg;
		pin_ctrl_next = pin_ctrl_reg;
		period_next = period_reg;
		duty_next = duty_reg;
		bvalid_next = bvalid_reg && !s_axi_bready;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg && !s_axi_rready;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (wr_go)
		begin
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			case (s_axi_awaddr)
				TB_CTRL_OFF: tb_ctrl_next = merge(tb_ctrl_reg, s_axi_wdata,
					s_axi_wstrb, TB_CTRL_MASK); // see (R7)
				PIN_CTRL_OFF: pin_ctrl_next = merge(pin_ctrl_reg, s_axi_wdata,
					s_axi_wstrb, PIN_CTRL_MASK); // see (R5)
				PERIOD_OFF: period_next = merge(period_reg, s_axi_wdata,
					s_axi_wstrb, CNT_MASK);
				DUTY_OFF: duty_next = merge(duty_reg, s_axi_wdata,
					s_axi_wstrb, CNT_MASK);
				STATUS_OFF: bresp_next = RESP_OKAY;
				default: bresp_next = RESP_SLVERR;
			endcase
		end
		if (rd_go)
		begin
			rvalid_next = 1'b1;
			rresp_next = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				TB_CTRL_OFF: rdata_next = tb_ctrl_reg;
				PIN_CTRL_OFF: rdata_next = pin_ctrl_reg;
				PERIOD_OFF: rdata_next = period_reg;
				DUTY_OFF: rdata_next = duty_reg;
				STATUS_OFF: rdata_next = {link.count, 13'h0000, sync_reg,
					held_reg, link.on};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tb_ctrl_reg <= TB_CTRL_RST;
			pin_ctrl_reg <= PIN_CTRL_RST;
			period_reg <= PERIOD_RST;
			duty_reg <= DUTY_RST;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			tb_ctrl_reg <= tb_ctrl_next;
			pin_ctrl_reg <= pin_ctrl_next;
			period_reg <= period_next;
			duty_reg <= duty_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	// time base runs only while enabled
	assign link.en = tb_ctrl_reg[TB_ON_BIT]; // see (R7)
	assign link.period = period_reg[CNT_W-1:0];
	assign link.duty = duty_reg[CNT_W-1:0];
	// a reset level carried over from ON time must not restart the period
	assign ext_rst_req = tb_ctrl_reg[EXT_RST_EN_BIT] && link.en &&
		ext_reset_in && !link.on && !held_reg; // see (R1) (R2)
	assign link.ext_rst = ext_rst_req;

	pwm_timebase u_timebase (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.link(link)
	);

	always_comb
	begin
		held_next = held_reg;
		if (!ext_reset_in)
			held_next = 1'b0;
		else if (link.on)
			held_next = 1'b1; // see (R2)
		// outputs change only through flops so the mux cannot glitch
		if (pin_ctrl_reg[HI_OWN_BIT]) // see (R4) (R12)
		begin
			oe_next[1] = 1'b1;
			out_next[1] = pin_ctrl_reg[HI_OVR_BIT] ?
				pin_ctrl_reg[OVR_HI_LVL_BIT] : link.on; // see (R6)
		end
		else
		begin
			oe_next[1] = !port_direction[1];
			out_next[1] = port_data[1];
		end
		if (pin_ctrl_reg[LO_OWN_BIT]) // see (R4) (R12)
		begin
			oe_next[0] = 1'b1;
			out_next[0] = pin_ctrl_reg[LO_OVR_BIT] ?
				pin_ctrl_reg[OVR_LO_LVL_BIT] : (link.en && !link.on); // see (R6)
		end
		else
		begin
			oe_next[0] = !port_direction[0];
			out_next[0] = port_data[0];
		end
		// sync pulse starts one cycle into each period except the first after enable, fixed width
		sync_next = link.en && (link.start ||
			(sync_reg && link.count < SYNC_CYC)); // see (R10)
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			held_reg <= 1'b0;
			out_reg <= 2'b00;
			oe_reg <= 2'b00;
			sync_reg <= 1'b0;
		end
		else
		begin
			held_reg <= held_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
			sync_reg <= sync_next;
		end
	end

	assign out_high = out_reg[1];
	assign out_low = out_reg[0];
	assign out_high_oe = oe_reg[1];
	assign out_low_oe = oe_reg[0];
	assign sync_out_secondary = sync_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence ext_held_in_on;
		ext_reset_in && link.on;
	endsequence
	sequence ext_still_high;
		ext_reset_in && !link.on;
	endsequence

	ext_restart_a: assert property (ext_rst_req |=> link.count == '0) // see (R1)
		else $error("ext reset in OFF time did not restart period");
	ext_ignore_a: assert property (ext_held_in_on ##1 ext_still_high[*1]
		|-> !ext_rst_req) // see (R2)
		else $error("held ext reset restarted period");
	owner_high_a: assert property (pin_ctrl_reg[HI_OWN_BIT] |=> out_high_oe) // see (R4)
		else $error("PWM-owned high pin not driven");
	// the release edge itself still shows reset levels on the pins
	port_low_a: assert property (rst_n && !pin_ctrl_reg[LO_OWN_BIT] |=>
		out_low_oe == !$past(port_direction[0]) &&
		out_low == $past(port_data[0])) // see (R4)
		else $error("port-owned low pin wrong");
	ovr_high_a: assert property (pin_ctrl_reg[HI_OWN_BIT] &&
		pin_ctrl_reg[HI_OVR_BIT] |=> out_high == $past(pin_ctrl_reg[1])) // see (R6)
		else $error("high override level wrong");
	ovr_low_a: assert property (pin_ctrl_reg[LO_OWN_BIT] &&
		pin_ctrl_reg[LO_OVR_BIT] |=> out_low == $past(pin_ctrl_reg[0])) // see (R5)
		else $error("low override level wrong");
	pwm_follow_a: assert property (pin_ctrl_reg[HI_OWN_BIT] &&
		!pin_ctrl_reg[HI_OVR_BIT] |=> out_high == $past(link.on)) // see (R12)
		else $error("high output not following PWM");
	tb_stop_a: assert property (!link.en ##1 !link.en |-> link.count == '0) // see (R7)
		else $error("time base counts while off");
	sync_width_a: assert property ($rose(sync_out_secondary) &&
		period_reg > 32'h0000_0010 |-> sync_out_secondary[*8]) // see (R10)
		else $error("sync pulse too short");
	wr_resp_a: assert property (wr_go |=> s_axi_bvalid)
		else $error("write response missing");
endmodule : pwm_output_ctrl
`default_nettype wire

// ### gate_drv_model.sv
/* gate driver stage with pull-downs, plus a slave sync input.
   assumes pins from the pwm output stage in the clk_sys domain. */
`timescale 1ns/1ps
`default_nettype none
module gate_drv_model
(
	input wire logic clk_sys,
	input wire logic out_high,
	input wire logic out_high_oe,
	input wire logic out_low,
	input wire logic out_low_oe,
	input wire logic sync_in,
	output logic pin_high,
	output logic pin_low,
	output logic [7:0] sync_width
);
	logic [7:0] run = 8'h00;
	initial sync_width = 8'h00;
	// released pins sit at the pull-down safe level
	assign pin_high = out_high_oe ? out_high : 1'b0;
	assign pin_low = out_low_oe ? out_low : 1'b0;
	// slave keeps the width of the last sync pulse it saw
	always @(posedge clk_sys)
	begin
		run <= sync_in ? run + 8'h01 : 8'h00;
		if (!sync_in && run != 8'h00)
			sync_width <= run;
	end
endmodule : gate_drv_model
`default_nettype wire

// ### testbench.sv
/* self-checking bench for the pwm output controller.
   assumes the package constants and a gate driver model. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pwm_out_pkg::*;
	logic clk_sys = 1'b0, rst_n = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = '0, rdata;
	logic [1:0] bresp, rresp, lv, dv, pdata = '0, pdir = '0;
	logic ext = 0, oh, ohe, ol, ole, sync, pin_h, pin_l;
	logic [7:0] sw;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int miscompares = 0, comparisons = 0, cyc = 0, n;
	localparam int P = 39, D = 10;
	always #5 clk_sys = ~clk_sys;
	pwm_output_ctrl pwm_output_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_reset_in(ext), .port_data(pdata),
		.port_direction(pdir), .out_high(oh), .out_high_oe(ohe),
		.out_low(ol), .out_low_oe(ole), .sync_out_secondary(sync));
	gate_drv_model gate_drv_model_inst (.clk_sys(clk_sys), .out_high(oh),
		.out_high_oe(ohe), .out_low(ol), .out_low_oe(ole), .sync_in(sync),
		.pin_high(pin_h), .pin_low(pin_l), .sync_width(sw));
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic end_of_test;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// ready is judged at the rising edge that takes the request
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
			@(posedge clk_sys);
		while (!awready);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do
			@(posedge clk_sys);
		while (!bvalid);
		bready <= 1'b0;
		// one idle edge so a following call never re-drives bready at once
		@(posedge clk_sys);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge clk_sys);
		while (!arready);
		arvalid <= 1'b0;
		do
			@(posedge clk_sys);
		while (!rvalid);
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask : rd
	task automatic rise(output int c);
		c = 0;
		@(negedge clk_sys);
		while (pin_h)
		begin
			@(negedge clk_sys);
			c++;
		end
		while (!pin_h)
		begin
			@(negedge clk_sys);
			c++;
		end
	endtask : rise
	always @(negedge clk_sys)
	begin
		if (rvalid && rready) check({rresp, rdata}, rq.pop_front());
		if (bvalid && bready) check({32'h0, bresp}, {32'h0, bq.pop_front()});
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	initial
	begin
		n = $urandom(55);
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(TB_CTRL_OFF, {RESP_OKAY, TB_CTRL_RST});
		rd(PIN_CTRL_OFF, {RESP_OKAY, PIN_CTRL_RST});
		rd(PERIOD_OFF, {RESP_OKAY, PERIOD_RST});
		rd(DUTY_OFF, {RESP_OKAY, DUTY_RST});
		rd(8'h14, {RESP_SLVERR, 32'h0});
		wr(8'h14, 32'h1, RESP_SLVERR);
		repeat (6)
		begin
			lv = 2'($urandom);
			dv = 2'($urandom);
			pdata <= lv;
			pdir <= dv;
			repeat (3) @(posedge clk_sys);
			check({32'h0, pin_h, pin_l}, {32'h0, lv & ~dv});
		end
		wr(PERIOD_OFF, P, RESP_OKAY);
		wr(DUTY_OFF, D, RESP_OKAY);
		for (int i = 0; i < 4; i++)
		begin
			wr(PIN_CTRL_OFF, 32'hC300 | i, RESP_OKAY);
			@(posedge clk_sys);
			check({32'h0, pin_h, pin_l}, 34'(i));
		end
		pdir <= 2'b11;
		wr(PIN_CTRL_OFF, 32'h0300, RESP_OKAY);
		wr(TB_CTRL_OFF, 32'h8001, RESP_OKAY);
		wr(PIN_CTRL_OFF, 32'h0000, RESP_OKAY);
		repeat (P + 5) @(posedge clk_sys);
		wr(PIN_CTRL_OFF, 32'hC000, RESP_OKAY);
		rise(n);
		n = 0;
		while (pin_h)
		begin
			@(negedge clk_sys);
			n++;
		end
		check(34'(n), 34'(D));
		check({33'h0, pin_l}, 34'h1);
		rise(n);
		check(34'(n), 34'(P - D));
		check({26'h0, sw}, {26'h0, SYNC_CYC[7:0]});
		repeat (D + 3) @(negedge clk_sys);
		@(posedge clk_sys);
		ext <= 1'b1;
		@(posedge clk_sys);
		ext <= 1'b0;
		rise(n);
		check({33'h0, n < 8}, 34'h1);
		@(posedge clk_sys);
		ext <= 1'b1;
		fork
			begin
				repeat (D + 5) @(posedge clk_sys);
				ext <= 1'b0;
			end
		join_none
		rise(n);
		check(34'(n), 34'(P));
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
